// ### core/bsr_top.sv
// boundary-scan test data registers with tap, pin cells and avalon status port
//
// The placing of the registers and the Avalon-MM register port are this design's own decisions.
`default_nettype none

module bsr_top #(
	parameter int IN_W = 8, // input pin cells
	parameter int OUT_W = 8, // output pin cells
	parameter logic [OUT_W-1:0] OUT_GRP = '0, // per output: 0 = active-low enable cell, 1 = active-high cell
	parameter logic [bsr_pkg::ID_W-1:0] ID_CODE = bsr_pkg::ID_CODE_DEF
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// jtag pins from the tester
	input wire logic TCK,
	input wire logic TMS,
	input wire logic TDI,
	input wire logic NTRST_N,
	output logic TDO,
	output logic TDO_OE,
	// pin side
	input wire logic [IN_W-1:0] PIN_IN,
	output logic [OUT_W-1:0] PIN_OUT,
	output logic [OUT_W-1:0] PIN_OE,
	// core side
	output logic [IN_W-1:0] CORE_IN,
	input wire logic [OUT_W-1:0] CORE_OUT,
	input wire logic CORE_OE_N_LO,
	input wire logic CORE_OE_HI,
	// avalon-mm slave
	input wire logic [bsr_pkg::AW-1:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [bsr_pkg::DW-1:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [bsr_pkg::DW-1:0] AVS_READDATA,
	output logic AVS_WAITREQUEST
);
	import bsr_pkg::*;

	// ****************************************
	// chain layout
	// ****************************************
	localparam int EN_W = 2; // enable cells: 0 active-low type, 1 active-high type
	localparam int CH = IN_W + OUT_W + EN_W; // chain length
	localparam int EN_LO = IN_W + OUT_W; // active_low_enable_cell_type index
	localparam int EN_HI = IN_W + OUT_W + 1; // active_high_enable_cell_type index

	// elaboration check: the chain needs at least one cell of each pin kind
	if (IN_W < 1 || OUT_W < 1) begin : g_chk
		$error("bsr_top: IN_W and OUT_W must be at least 1");
	end

	// ****************************************
	// state of the block
	// ****************************************
	typedef struct packed {
		logic tck_s1; // synchroniser first stages
		logic tck_s2;
		logic tck_s3; // previous tck level for edge finding
		logic tms_s1;
		logic tms_s2;
		logic tdi_s1;
		logic tdi_s2;
		logic trst_s1;
		logic trst_s2;
		logic [IN_W-1:0] pin_s1;
		logic [IN_W-1:0] pin_s2;
		bsr_tap_e tap;
		logic [IR_W-1:0] ir_sh; // instruction shift stage
		logic [IR_W-1:0] ir; // current instruction
		logic byp; // bypass cell
		logic [ID_W-1:0] id_sh; // identification shift register
		logic [CH-1:0] bs_sh; // chain shift stages
		logic [CH-1:0] bs_upd; // chain update stages
		logic tdo;
		logic tdo_oe;
		logic [IN_W-1:0] core_in;
		logic [OUT_W-1:0] pin_out;
		logic [OUT_W-1:0] pin_oe;
		logic tap_en; // software control
		logic wait_n; // waitrequest low phase
		logic waitreq; // waitrequest as driven on the bus
		logic [DW-1:0] rdata;
	} bsr_state_s;

	bsr_state_s s_q, s_d;

	// ****************************************
	// tap next state
	// ****************************************
	function automatic bsr_tap_e tap_next(input bsr_tap_e st, input logic tms);
		bsr_tap_e nx;
		nx = st;
		unique case (st)
			TAP_RESET: nx = tms ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: nx = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: nx = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: nx = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: nx = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: nx = tms ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: nx = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: nx = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: nx = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
		endcase
		return nx;
	endfunction

	// ****************************************
	// decode of the current instruction
	// ****************************************
	logic is_ext, is_int, is_smp, is_clamp, is_clamp_with_tristate_instruction, is_highz, is_id;
	logic bs_sel, test_mode, use_upd;
	logic tck_rise, tck_fall;
	logic [EN_W-1:0] en_ctrl; // value seen by the enable controls
	logic [EN_W-1:0] drive; // group drives its pins
	logic tdo_src;

	// instruction flags and path selection
	always_comb begin
		is_ext = (s_q.ir == INS_EXTEST);
		is_int = (s_q.ir == INS_INTEST);
		is_smp = (s_q.ir == INS_SAMPLE);
		is_clamp = (s_q.ir == INS_CLAMP);
		is_clamp_with_tristate_instruction = (s_q.ir == INS_CLAMP_WITH_TRISTATE_INSTRUCTION);
		is_highz = (s_q.ir == INS_HIGHZ);
		is_id = (s_q.ir == INS_IDCODE);
		bs_sel = is_ext | is_int | is_smp;
		test_mode = is_ext | is_int;
		// clamps drive pins from update stages
		use_upd = test_mode | is_clamp | is_clamp_with_tristate_instruction;
		// edges found by sampling, no timeouts
		tck_rise = s_q.tck_s2 & ~s_q.tck_s3;
		tck_fall = ~s_q.tck_s2 & s_q.tck_s3;
		// enable cells not tied to pins
		en_ctrl[0] = use_upd ? s_q.bs_upd[EN_LO] : CORE_OE_N_LO;
		en_ctrl[1] = use_upd ? s_q.bs_upd[EN_HI] : CORE_OE_HI;
		// active-low cell one floats, active-high zero
		drive[0] = ~en_ctrl[0];
		drive[1] = en_ctrl[1];
		if (is_highz | is_clamp_with_tristate_instruction) begin
			drive = '0;
		end
		if (s_q.tap == TAP_SHIFT_IR) begin
			tdo_src = s_q.ir_sh[0];
		end else if (bs_sel) begin
			tdo_src = s_q.bs_sh[CH-1];
		end else if (is_id) begin
			tdo_src = s_q.id_sh[0];
		end else begin
			// all other codes use the bypass cell
			tdo_src = s_q.byp;
		end
	end

	// ****************************************
	// next state
	// ****************************************
	// one pass builds the whole next state; pins, tap, chain and bus
	always_comb begin
		s_d = s_q;
		// synchronisers: first stage only feeds the second
		s_d.tck_s1 = TCK;
		s_d.tck_s2 = s_q.tck_s1;
		s_d.tck_s3 = s_q.tck_s2;
		s_d.tms_s1 = TMS;
		s_d.tms_s2 = s_q.tms_s1;
		s_d.tdi_s1 = TDI;
		s_d.tdi_s2 = s_q.tdi_s1;
		s_d.trst_s1 = NTRST_N;
		s_d.trst_s2 = s_q.trst_s1;
		s_d.pin_s1 = PIN_IN;
		s_d.pin_s2 = s_q.pin_s1;

		// rising tck: tap step plus capture or shift of the selected register
		if (tck_rise) begin
			s_d.tap = tap_next(s_q.tap, s_q.tms_s2);
			unique case (s_q.tap)
				TAP_CAP_IR: s_d.ir_sh = IR_CAPTURE;
				TAP_SHIFT_IR: s_d.ir_sh = {s_q.tdi_s2, s_q.ir_sh[IR_W-1:1]};
				TAP_CAP_DR: begin
					if (bs_sel) begin
						for (int i = 0; i < IN_W; i++) begin
							// intest captures complement of core stimulus
							s_d.bs_sh[i] = is_int ? ~s_q.core_in[i] : s_q.pin_s2[i];
						end
						for (int j = 0; j < OUT_W; j++) begin
							s_d.bs_sh[IN_W+j] = is_int ? CORE_OUT[j] : s_q.pin_out[j];
						end
						// enable cells capture the core's controls under intest
						// and the level that drives the pins otherwise
						s_d.bs_sh[EN_LO] = is_int ? CORE_OE_N_LO : en_ctrl[0];
						s_d.bs_sh[EN_HI] = is_int ? CORE_OE_HI : en_ctrl[1];
					end else if (is_id) begin
						s_d.id_sh = ID_CODE;
					end else begin
						s_d.byp = 1'b0;
					end
				end
				TAP_SHIFT_DR: begin
					if (bs_sel) begin
						s_d.bs_sh = {s_q.bs_sh[CH-2:0], s_q.tdi_s2};
					end else if (is_id) begin
						s_d.id_sh = {s_q.tdi_s2, s_q.id_sh[ID_W-1:1]};
					end else begin
						// one tck of delay through bypass
						s_d.byp = s_q.tdi_s2;
					end
				end
				default: begin
				end
			endcase
		end

		// falling tck: tdo, its enable, and the update stages
		if (tck_fall) begin
			s_d.tdo = tdo_src;
			s_d.tdo_oe = (s_q.tap == TAP_SHIFT_DR) || (s_q.tap == TAP_SHIFT_IR);
			if (s_q.tap == TAP_UPD_IR) begin
				s_d.ir = s_q.ir_sh;
			end
			// every cell has its own update stage
			if (s_q.tap == TAP_UPD_DR && bs_sel) begin
				s_d.bs_upd = s_q.bs_sh;
			end
		end

		// ntrst low or software hold restores system mode
		if (!s_q.trst_s2 || !s_q.tap_en) begin
			s_d.tap = TAP_RESET;
			s_d.ir = INS_IDCODE;
			s_d.tdo_oe = 1'b0;
		end else if (s_q.tap == TAP_RESET) begin
			s_d.ir = INS_IDCODE;
		end

		// pin and core drivers, registered so outputs come from flops
		for (int i = 0; i < IN_W; i++) begin
			// test modes feed core from update stages
			// otherwise pins pass straight to the core
			s_d.core_in[i] = test_mode ? s_q.bs_upd[i] : s_q.pin_s2[i];
		end
		for (int j = 0; j < OUT_W; j++) begin
			s_d.pin_out[j] = use_upd ? s_q.bs_upd[IN_W+j] : CORE_OUT[j];
			s_d.pin_oe[j] = drive[OUT_GRP[j]];
		end

		// avalon slave: one wait cycle, then answer for one cycle
		if ((AVS_READ || AVS_WRITE) && !s_q.wait_n) begin
			s_d.wait_n = 1'b1;
			s_d.rdata = '0;
			unique case (AVS_ADDRESS)
				REG_CTRL: s_d.rdata[CTRL_TAP_EN] = s_q.tap_en;
				REG_STATUS: begin
					s_d.rdata[ST_TAP_LSB +: 4] = s_q.tap;
					s_d.rdata[ST_IR_LSB +: IR_W] = s_q.ir;
					s_d.rdata[ST_TEST] = test_mode;
					s_d.rdata[ST_TDO_OE] = s_q.tdo_oe;
				end
				REG_IDCODE: s_d.rdata = ID_CODE;
				default: s_d.rdata = '0; // unmapped reads zero
			endcase
		end else begin
			s_d.wait_n = 1'b0;
		end
		// write takes effect at the edge that sees waitrequest low
		if (AVS_WRITE && s_q.wait_n && AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) begin
			s_d.tap_en = AVS_WRITEDATA[CTRL_TAP_EN];
		end
		// waitrequest has its own flop so the pin needs no inverter after the register
		s_d.waitreq = ~s_d.wait_n;
	end

	// ****************************************
	// state register
	// ****************************************
	// chain data cleared only by rst, never by ntrst
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			s_q <= '0;
			s_q.tck_s1 <= 1'b0;
			s_q.tap <= TAP_RESET;
			s_q.ir <= INS_IDCODE;
			s_q.tap_en <= CTRL_TAP_EN_RST;
			s_q.waitreq <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from flops; no parallel output of bypass or id
	// bypass cell reaches tdo only
	assign TDO = s_q.tdo;
	assign TDO_OE = s_q.tdo_oe;
	assign PIN_OUT = s_q.pin_out;
	assign PIN_OE = s_q.pin_oe;
	assign CORE_IN = s_q.core_in;
	assign AVS_READDATA = s_q.rdata;
	assign AVS_WAITREQUEST = s_q.waitreq;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);

	logic cap_rise;
	assign cap_rise = tck_rise && s_q.tap == TAP_CAP_DR && s_q.trst_s2 && s_q.tap_en;

	a_bypass_capture: assert property (cap_rise && !bs_sel && !is_id |=> s_q.byp == 1'b0)
		else $error("bypass cell did not capture zero");
	a_id_capture: assert property (cap_rise && is_id |=> s_q.id_sh == ID_CODE)
		else $error("identification code not loaded");
	a_tdo_enable: assert property (tck_fall && s_q.trst_s2 && s_q.tap_en
		|=> TDO_OE == ($past(s_q.tap) inside {TAP_SHIFT_DR, TAP_SHIFT_IR}))
		else $error("tdo enable does not follow shift state");
	a_chain_hold: assert property (!bs_sel && !(s_q.tap == TAP_CAP_DR) |=> $stable(s_q.bs_sh))
		else $error("chain moved while not selected");
	a_clamp_keep: assert property ((is_clamp || is_clamp_with_tristate_instruction) ##1 (is_clamp || is_clamp_with_tristate_instruction)
		|-> $stable(s_q.bs_upd) && $stable(s_q.bs_sh))
		else $error("clamp changed chain contents");
	a_normal_pass: assert property (!use_upd |=> PIN_OUT == $past(CORE_OUT) && CORE_IN == $past(s_q.pin_s2))
		else $error("system mode not straight through");
	a_test_core: assert property (test_mode |=> CORE_IN == $past(s_q.bs_upd[IN_W-1:0]))
		else $error("core inputs not from update stages");
	a_highz_float: assert property (is_highz |=> PIN_OE == '0)
		else $error("highz left an output enabled");
	a_trst_reset: assert property (!s_q.trst_s2 |=> s_q.tap == TAP_RESET && s_q.ir == INS_IDCODE)
		else $error("ntrst did not reset tap");
	a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request not answered in one cycle");

	c_bypass_shift: cover property (tck_rise && s_q.tap == TAP_SHIFT_DR && !bs_sel && !is_id);
	c_id_capture: cover property (cap_rise && is_id);
	c_intest_update: cover property (tck_fall && s_q.tap == TAP_UPD_DR && is_int);
	c_highz: cover property (is_highz ##1 PIN_OE == '0);

endmodule

`default_nettype wire

// ### core/bsr_pkg.sv
// constants, instruction codes and register map of the boundary-scan test data registers
`default_nettype none

package bsr_pkg;

	// ****************************************
	// instruction register
	// ****************************************
	localparam int IR_W = 4; // instruction width
	localparam logic [IR_W-1:0] INS_EXTEST = 4'h0;
	localparam logic [IR_W-1:0] INS_SAMPLE = 4'h3;
	localparam logic [IR_W-1:0] INS_CLAMP = 4'h5;
	localparam logic [IR_W-1:0] INS_HIGHZ = 4'h7;
	localparam logic [IR_W-1:0] INS_CLAMP_WITH_TRISTATE_INSTRUCTION = 4'h9; // clamp_with_tristate_instruction
	localparam logic [IR_W-1:0] INS_INTEST = 4'hC;
	localparam logic [IR_W-1:0] INS_IDCODE = 4'hE;
	localparam logic [IR_W-1:0] INS_BYPASS = 4'hF;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1; // pattern loaded in capture-ir

	// ****************************************
	// identification register
	// ****************************************
	localparam int ID_W = 32;
	localparam logic [ID_W-1:0] ID_CODE_DEF = 32'h0000_0001; // arbitrary value, lsb set as required

	// ****************************************
	// tap controller states
	// ****************************************
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4,
		TAP_EXIT1_DR = 4'h5,
		TAP_PAUSE_DR = 4'h6,
		TAP_EXIT2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'hA,
		TAP_SHIFT_IR = 4'hB,
		TAP_EXIT1_IR = 4'hC,
		TAP_PAUSE_IR = 4'hD,
		TAP_EXIT2_IR = 4'hE,
		TAP_UPD_IR = 4'hF
	} bsr_tap_e;

	// ****************************************
	// avalon register map (byte addresses)
	// ****************************************
	localparam int AW = 4;
	localparam int DW = 32;
	localparam logic [AW-1:0] REG_CTRL = 4'h0;
	localparam logic [AW-1:0] REG_STATUS = 4'h4;
	localparam logic [AW-1:0] REG_IDCODE = 4'h8;
	localparam int CTRL_TAP_EN = 0; // 1: tap runs, 0: tap held in test-logic-reset
	localparam logic CTRL_TAP_EN_RST = 1'b1;
	localparam int ST_TAP_LSB = 0; // status [3:0] tap state
	localparam int ST_IR_LSB = 4; // status [7:4] current instruction
	localparam int ST_TEST = 8; // status [8] extest or intest active
	localparam int ST_TDO_OE = 9; // status [9] tdo enabled

endpackage

`default_nettype wire

// ### tb/bsr_tester.sv
// jtag tester model that drives the test access port from the far side
`default_nettype none

module bsr_tester (
	// pacing clock
	input wire logic clk,
	// jtag pins
	output logic tck,
	output logic tms,
	output logic tdi,
	output logic ntrst_n,
	input wire logic tdo,
	input wire logic tdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	int hold = 0; // extra high-phase cycles, parks tck high mid-frame
	logic oe_seen = 1'b1; // and of tdo_oe over every shifted bit
	// tck idles low outside frames; it never runs free
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
		ntrst_n = 1'b1;
	end
	// one tck period of 8 system cycles plus hold; tdo is read at the closing fall, before it moves
	task automatic tbit(input logic m, input logic d, output logic o);
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge clk);
		tck <= 1'b1;
		repeat (4 + hold) @(posedge clk);
		tck <= 1'b0;
		// a released tdo shows the inverse of its last bit, so a missing enable cannot pass
		o = tdo_oe ? tdo : ~tdo;
	endtask
	task automatic trst();
		logic o;
		tms <= 1'b1;
		ntrst_n <= 1'b0;
		repeat (8) @(posedge clk);
		ntrst_n <= 1'b1;
		repeat (8) @(posedge clk);
		tbit(1'b0, 1'b1, o);
	endtask
	// scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
		logic o;
		dout = '0;
		tbit(1'b1, 1'b0, o);
		if (ir) begin
			tbit(1'b1, 1'b1, o);
		end
		tbit(1'b0, 1'b0, o);
		tbit(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++) begin
			tbit(i == n - 1, din[i], o);
			dout[i] = o;
			oe_seen = oe_seen & tdo_oe;
		end
		// released data line shows the inverse, not a stale copy
		tbit(1'b1, ~din[n-1], o);
		tbit(1'b0, din[n-1], o);
	endtask
endmodule

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the boundary-scan data registers
`default_nettype none

module tb;
	import bsr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CL = 10; // chain: 4 inputs, 4 outputs, 2 enable cells
	localparam logic [31:0] IDV = 32'h1234_5671; // arbitrary identification value
	localparam logic [3:0] BYP [5] = '{INS_BYPASS, INS_CLAMP, INS_HIGHZ, INS_CLAMP_WITH_TRISTATE_INSTRUCTION, 4'h1};
	logic CORE_CLK = 1'b0;
	logic RST = 1'b1;
	logic TCK, TMS, TDI, NTRST_N, TDO, TDO_OE, AVS_WAITREQUEST;
	logic [3:0] PIN_IN = 4'h0, CORE_OUT = 4'h0, AVS_ADDRESS = 4'h0, PIN_OUT, PIN_OE, CORE_IN;
	logic CORE_OE_N_LO = 1'b0, CORE_OE_HI = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
	logic [63:0] so; // word last shifted out
	int n_fail = 0, tests_run = 0, cyc = 0;
	initial forever #5 CORE_CLK = ~CORE_CLK;
	// outputs 3:2 use the active-high enable cell, 1:0 the active-low one
	bsr_top #(.IN_W(4), .OUT_W(4), .OUT_GRP(4'hC), .ID_CODE(IDV)) u_dut (.CORE_CLK(CORE_CLK), .RST(RST),
		.TCK(TCK), .TMS(TMS), .TDI(TDI), .NTRST_N(NTRST_N), .TDO(TDO), .TDO_OE(TDO_OE), .PIN_IN(PIN_IN),
		.PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .CORE_IN(CORE_IN), .CORE_OUT(CORE_OUT),
		.CORE_OE_N_LO(CORE_OE_N_LO), .CORE_OE_HI(CORE_OE_HI), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
	bsr_tester u_tst (.clk(CORE_CLK), .tck(TCK), .tms(TMS), .tdi(TDI), .ntrst_n(NTRST_N), .tdo(TDO),
		.tdo_oe(TDO_OE));
	// ****************************************
	// helpers
	// ****************************************
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// hang guard, well above the expected run length
	always @(posedge CORE_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one avalon transfer; request held until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
		@(posedge CORE_CLK);
		AVS_READ <= ~wr;
		AVS_WRITE <= wr;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= wd;
		do begin
			@(posedge CORE_CLK);
		end while (AVS_WAITREQUEST !== 1'b0);
		q = AVS_READDATA;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask
	// status word: tdo enable, test mode, instruction, tap state
	function automatic logic [31:0] st(input logic [3:0] tap, input logic [3:0] ir, input logic t);
		return {22'h0, 1'b0, t, ir, tap};
	endfunction
	// chain word in shift order: enable-high cell leaves first, input 0 last
	function automatic logic [63:0] cv(input logic hi, input logic lo, input logic [3:0] o, input logic [3:0] i);
		logic [9:0] t;
		t = {<<{hi, lo, o, i}};
		return {54'h0, t};
	endfunction
	// ****************************************
	// tests
	// ****************************************
	initial begin
		repeat (4) @(posedge CORE_CLK);
		RST <= 1'b0;
		repeat (3) @(posedge CORE_CLK);
		rdc(REG_CTRL, 32'h0000_0001);
		rdc(REG_STATUS, st(TAP_RESET, INS_IDCODE, 1'b0));
		rdc(REG_IDCODE, IDV);
		rdc(4'hC, 32'h0);
		bus(1'b1, REG_IDCODE, 32'hFFFF_0000, rd);
		rdc(REG_IDCODE, IDV);
		$display("test registers done");
		u_tst.trst();
		u_tst.scan(1'b0, 32, 64'hA5A5_0F0F, so);
		chk(so, {32'h0, IDV});
		u_tst.hold = 40;
		u_tst.scan(1'b0, 32, 64'h0, so);
		u_tst.hold = 0;
		chk(so, {32'h0, IDV});
		chk(u_tst.oe_seen, 1'b1);
		chk(TDO_OE, 1'b0);
		$display("test identification done");
		foreach (BYP[i]) begin
			u_tst.scan(1'b1, 4, {60'h0, BYP[i]}, so);
			chk(so, 64'h1);
			rdc(REG_STATUS, st(TAP_IDLE, BYP[i], 1'b0));
			u_tst.scan(1'b0, 4, 64'hB, so);
			chk(so, 64'h6);
		end
		$display("test bypass done");
		u_tst.scan(1'b1, 4, {60'h0, INS_SAMPLE}, so);
		PIN_IN <= 4'hA;
		CORE_OUT <= 4'h5;
		CORE_OE_N_LO <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		chk({CORE_IN, PIN_OUT, PIN_OE}, 12'hA5C);
		u_tst.scan(1'b0, CL, cv(1'b1, 1'b0, 4'h6, 4'h9), so);
		chk(so, cv(1'b1, 1'b1, 4'h5, 4'hA));
		chk({CORE_IN, PIN_OUT, PIN_OE}, 12'hA5C);
		$display("test sample done");
		u_tst.scan(1'b1, 4, {60'h0, INS_EXTEST}, so);
		PIN_IN <= 4'h3;
		repeat (5) @(posedge CORE_CLK);
		chk({CORE_IN, PIN_OUT, PIN_OE}, 12'h96F);
		rdc(REG_STATUS, st(TAP_IDLE, INS_EXTEST, 1'b1));
		u_tst.scan(1'b1, 4, {60'h0, INS_CLAMP}, so);
		u_tst.scan(1'b0, 4, 64'hF, so);
		chk({PIN_OUT, PIN_OE}, 8'h6F);
		u_tst.scan(1'b1, 4, {60'h0, INS_CLAMP_WITH_TRISTATE_INSTRUCTION}, so);
		chk({PIN_OUT, PIN_OE}, 8'h60);
		u_tst.scan(1'b1, 4, {60'h0, INS_HIGHZ}, so);
		chk(PIN_OE, 4'h0);
		u_tst.scan(1'b1, 4, {60'h0, INS_EXTEST}, so);
		chk({CORE_IN, PIN_OUT, PIN_OE}, 12'h96F);
		u_tst.scan(1'b0, CL, cv(1'b0, 1'b1, 4'hC, 4'h2), so);
		chk(so, cv(1'b1, 1'b0, 4'h6, 4'h3));
		chk({CORE_IN, PIN_OUT, PIN_OE}, 12'h2C0);
		$display("test extest and clamps done");
		u_tst.scan(1'b1, 4, {60'h0, INS_SAMPLE}, so);
		CORE_OE_HI <= 1'b0;
		u_tst.scan(1'b0, CL, cv(1'b0, 1'b1, 4'h0, 4'h5), so);
		u_tst.scan(1'b1, 4, {60'h0, INS_INTEST}, so);
		CORE_OUT <= 4'hB;
		// core raises its active-high control while the update stage holds zero
		CORE_OE_HI <= 1'b1;
		chk({CORE_IN, PIN_OE}, 8'h50);
		u_tst.scan(1'b0, CL, cv(1'b0, 1'b1, 4'h0, 4'hE), so);
		chk(so, cv(1'b1, 1'b1, 4'hB, 4'hA));
		chk(CORE_IN, 4'hE);
		$display("test intest step done");
		u_tst.trst();
		PIN_IN <= 4'h7;
		repeat (5) @(posedge CORE_CLK);
		rdc(REG_STATUS, st(TAP_IDLE, INS_IDCODE, 1'b0));
		chk(CORE_IN, 4'h7);
		bus(1'b1, REG_CTRL, 32'h0, rd);
		u_tst.scan(1'b1, 4, {60'h0, INS_BYPASS}, so);
		rdc(REG_STATUS, st(TAP_RESET, INS_IDCODE, 1'b0));
		bus(1'b1, REG_CTRL, 32'h0000_0001, rd);
		rdc(REG_CTRL, 32'h0000_0001);
		$display("test reset done");
		stop_test();
	end
endmodule

`default_nettype wire
